/* src/vcb_comparator_ctrl.sv */
// Control logic of the voltage comparator block
//
// Chosen here: the Avalon-MM register port and the register offsets.
`timescale 1ns/10ps
module vcb_comparator_ctrl
  import vcb_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  // Avalon-MM slave
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Power mode status from the system
  input wire logic wait_mode_in,
  input wire logic light_stop_mode_in,
  input wire logic deepest_stop_mode_in,
  input wire logic debug_halt_in,
  // Analog comparator interface
  input wire logic analog_result_in,
  output logic comparator_power_out,
  output logic analog_low_power_out,
  output logic reference_source_select_out,
  output logic bandgap_buffer_enable_out,
  // Result pin
  output logic result_output_pin_out,
  output logic result_output_pin_oe_out,
  // Timer routing
  output logic capture_ch0_out,
  output logic capture_route_active_out,
  output logic timer_channel_zero_pin_disconnect_out,
  // Interrupt
  output logic compare_irq_out
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed
  {
    logic comparator_module_enable;
    logic reference_source_select;
    logic compare_event_flag;
    logic compare_irq_enable;
    logic result_pin_enable;
    logic [1:0] event_edge_select;
    logic result_to_capture_route;
    logic bandgap_buffer_enable;
    vcb_bus_state_t bus;
    logic [31:0] rdata;
    logic comp_pwr;
    logic low_pwr;
    logic ref_sel;
    logic bg_buf;
    logic pin_val;
    logic pin_oe;
    logic cap_val;
    logic route;
    logic irq;
  } vcb_state_t;

  vcb_state_t st_r;
  vcb_state_t st_nxt;

  logic running;
  logic live_level;
  logic edge_event;
  logic live_bit;
  logic [7:0] ctrl_view;
  logic wr_hit;
  logic lane0;

  // ----------------------------------------------------------------
  // Run gating and synchroniser
  // ----------------------------------------------------------------
  // stop disables block
  // wait and debug do not gate
  assign running = st_r.comparator_module_enable & ~light_stop_mode_in & ~deepest_stop_mode_in;

  vcb_edge_detect u_edge
  (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .run_in(running),
    .async_in(analog_result_in),
    .edge_sel_in(st_r.event_edge_select),
    .level_out(live_level),
    .event_out(edge_event)
  );

  assign live_bit = st_r.comparator_module_enable & live_level;

  // Register read view
  assign ctrl_view = {st_r.comparator_module_enable, st_r.reference_source_select,
                      st_r.compare_event_flag, st_r.compare_irq_enable, live_bit,
                      st_r.result_pin_enable, st_r.event_edge_select};

  assign wr_hit = avs_write_in & (st_r.bus == VCB_BUS_IDLE);
  assign lane0 = avs_byteenable_in[0];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;

    // Bus slave: one wait cycle, answer on second cycle
    case (st_r.bus)
      VCB_BUS_IDLE:
      begin
        if (avs_read_in | avs_write_in)
        begin
          st_nxt.bus = VCB_BUS_DONE;
        end
        if (avs_read_in)
        begin
          case (avs_address_in)
            VCB_ADDR_CTRL: st_nxt.rdata = {24'h000000, ctrl_view};
            VCB_ADDR_SYS: st_nxt.rdata = {30'h0, st_r.bandgap_buffer_enable,
                                          st_r.result_to_capture_route};
            VCB_ADDR_MODE: st_nxt.rdata = {30'h0, deepest_stop_mode_in, light_stop_mode_in};
            default: st_nxt.rdata = 32'h00000000;
          endcase
        end
      end
      VCB_BUS_DONE:
      begin
        st_nxt.bus = VCB_BUS_IDLE;
      end
      default:
      begin
        st_nxt.bus = VCB_BUS_IDLE;
      end
    endcase

    if (wr_hit && lane0 && !light_stop_mode_in && avs_address_in == VCB_ADDR_CTRL)
    begin
      st_nxt.comparator_module_enable = avs_writedata_in[VCB_BIT_ENABLE];
      st_nxt.reference_source_select = avs_writedata_in[VCB_BIT_REFSEL];
      st_nxt.compare_irq_enable = avs_writedata_in[VCB_BIT_IRQEN];
      st_nxt.result_pin_enable = avs_writedata_in[VCB_BIT_PINEN];
      st_nxt.event_edge_select = avs_writedata_in[VCB_BIT_EDGE_HI:VCB_BIT_EDGE_LO];
      if (avs_writedata_in[VCB_BIT_FLAG])
      begin
        st_nxt.compare_event_flag = 1'b0;
      end
    end
    if (wr_hit && lane0 && !light_stop_mode_in && avs_address_in == VCB_ADDR_SYS)
    begin
      st_nxt.result_to_capture_route = avs_writedata_in[VCB_BIT_ROUTE];
      st_nxt.bandgap_buffer_enable = avs_writedata_in[VCB_BIT_BGBUF];
    end

    if (edge_event && running)
    begin
      st_nxt.compare_event_flag = 1'b1;
    end

    if (deepest_stop_mode_in)
    begin
      st_nxt.comparator_module_enable = VCB_CTRL_RST[VCB_BIT_ENABLE];
      st_nxt.reference_source_select = VCB_CTRL_RST[VCB_BIT_REFSEL];
      st_nxt.compare_event_flag = VCB_CTRL_RST[VCB_BIT_FLAG];
      st_nxt.compare_irq_enable = VCB_CTRL_RST[VCB_BIT_IRQEN];
      st_nxt.result_pin_enable = VCB_CTRL_RST[VCB_BIT_PINEN];
      st_nxt.event_edge_select = VCB_EDGE_RST;
      st_nxt.result_to_capture_route = 1'b0;
      st_nxt.bandgap_buffer_enable = 1'b0;
    end

    // Registered outputs
    st_nxt.comp_pwr = running;
    // analog low power in light stop
    st_nxt.low_pwr = light_stop_mode_in;
    st_nxt.ref_sel = st_nxt.reference_source_select;
    st_nxt.bg_buf = st_nxt.bandgap_buffer_enable;
    st_nxt.pin_oe = st_nxt.result_pin_enable & st_nxt.comparator_module_enable;
    st_nxt.pin_val = st_nxt.pin_oe & live_level & running;
    st_nxt.cap_val = st_nxt.result_to_capture_route & live_level & running;
    st_nxt.route = st_nxt.result_to_capture_route;
    st_nxt.irq = st_nxt.compare_irq_enable & st_nxt.compare_event_flag
                 & ~light_stop_mode_in & ~deepest_stop_mode_in;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // reset returns reset state
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all from flops
  // ----------------------------------------------------------------
  assign avs_readdata_out = st_r.rdata;
  assign avs_waitrequest_out = (st_r.bus == VCB_BUS_IDLE); // High until answer cycle
  assign comparator_power_out = st_r.comp_pwr;
  assign analog_low_power_out = st_r.low_pwr;
  assign reference_source_select_out = st_r.ref_sel;
  assign bandgap_buffer_enable_out = st_r.bg_buf;
  assign result_output_pin_out = st_r.pin_val;
  assign result_output_pin_oe_out = st_r.pin_oe;
  assign capture_ch0_out = st_r.cap_val;
  assign capture_route_active_out = st_r.route;
  assign timer_channel_zero_pin_disconnect_out = st_r.route;
  assign compare_irq_out = st_r.irq;

endmodule : vcb_comparator_ctrl

/* inc/vcb_pkg.sv */
// Package for the voltage comparator block control logic
package vcb_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses on the Avalon-MM slave)
  // ----------------------------------------------------------------
  localparam logic [3:0] VCB_ADDR_CTRL = 4'h0;  // status and control
  localparam logic [3:0] VCB_ADDR_SYS = 4'h4;   // system routing and power options
  localparam logic [3:0] VCB_ADDR_MODE = 4'h8;  // power mode status, read only

  // ----------------------------------------------------------------
  // Control register field positions
  // ----------------------------------------------------------------
  localparam int VCB_BIT_ENABLE = 7;
  localparam int VCB_BIT_REFSEL = 6;
  localparam int VCB_BIT_FLAG = 5;
  localparam int VCB_BIT_IRQEN = 4;
  localparam int VCB_BIT_LIVE = 3;
  localparam int VCB_BIT_PINEN = 2;
  localparam int VCB_BIT_EDGE_HI = 1;
  localparam int VCB_BIT_EDGE_LO = 0;

  // System register field positions
  localparam int VCB_BIT_ROUTE = 0;
  localparam int VCB_BIT_BGBUF = 1;

  // Mode register field positions
  localparam int VCB_BIT_M_LIGHT = 0;
  localparam int VCB_BIT_M_DEEP = 1;

  // Reset values
  localparam logic [7:0] VCB_CTRL_RST = 8'h00;
  localparam logic [1:0] VCB_EDGE_RST = 2'h0;

  // Event edge encodings
  localparam logic [1:0] VCB_EDGE_FALL0 = 2'h0;
  localparam logic [1:0] VCB_EDGE_RISE = 2'h1;
  localparam logic [1:0] VCB_EDGE_FALL2 = 2'h2;
  localparam logic [1:0] VCB_EDGE_BOTH = 2'h3;

  // Bus slave state
  typedef enum logic [0:0]
  {
    VCB_BUS_IDLE = 1'b0,
    VCB_BUS_DONE = 1'b1
  } vcb_bus_state_t;

endpackage : vcb_pkg

/* src/vcb_edge_detect.sv */
// Two-flop synchroniser and programmable edge detector
`timescale 1ns/10ps
module vcb_edge_detect
  import vcb_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic run_in,
  input wire logic async_in,
  input wire logic [1:0] edge_sel_in,
  output logic level_out,
  output logic event_out
);

  typedef struct packed
  {
    logic meta;
    logic sync;
    logic prev;
    logic evt;
  } vcb_edge_state_t;

  vcb_edge_state_t st_r;
  vcb_edge_state_t st_nxt;
  logic rise;
  logic fall;

  // ----------------------------------------------------------------
  // Synchroniser and edge selection
  // ----------------------------------------------------------------
  // Meta stage is read only by the sync stage
  always_comb
  begin
    st_nxt = st_r;
    rise = st_r.sync & ~st_r.prev;
    fall = ~st_r.sync & st_r.prev;
    if (run_in)
    begin
      st_nxt.meta = async_in;
      st_nxt.sync = st_r.meta;
      st_nxt.prev = st_r.sync;
      case (edge_sel_in)
        VCB_EDGE_RISE: st_nxt.evt = rise;
        VCB_EDGE_FALL0: st_nxt.evt = fall;
        VCB_EDGE_FALL2: st_nxt.evt = fall;
        VCB_EDGE_BOTH: st_nxt.evt = rise | fall;
        default: st_nxt.evt = 1'b0;
      endcase
    end
    else
    begin
      // Disabled: history cleared, so re-enable with the input high makes a rising edge
      st_nxt = '0;
    end
  end

  // State register
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign level_out = st_r.sync;
  assign event_out = st_r.evt;

endmodule : vcb_edge_detect

/* tb/vcb_analog_model.sv */
// Behavioural model of the analog comparator at the block's far side
`timescale 1ns/10ps
module vcb_analog_model
(
  input wire logic sel_in,
  input wire logic pin_in,
  input wire logic bandgap_in,
  output logic result_out
);
  // source select
  // Output follows the chosen non-inverting source against a fixed threshold
  assign result_out = sel_in ? bandgap_in : pin_in;
endmodule : vcb_analog_model

/* tb/vcb_comparator_ctrl_chk.sv */
// Port assertions for the comparator control block
`timescale 1ns/10ps
module vcb_comparator_ctrl_chk
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic light_stop_mode_in,
  input wire logic deepest_stop_mode_in,
  input wire logic analog_result_in,
  input wire logic avs_waitrequest_out,
  input wire logic comparator_power_out,
  input wire logic analog_low_power_out,
  input wire logic reference_source_select_out,
  input wire logic result_output_pin_out,
  input wire logic result_output_pin_oe_out,
  input wire logic capture_ch0_out,
  input wire logic capture_route_active_out,
  input wire logic timer_channel_zero_pin_disconnect_out,
  input wire logic compare_irq_out
);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  route_cut_a: assert property (capture_route_active_out == timer_channel_zero_pin_disconnect_out)
    else $error("timer pin cut differs from route");
  // capture feed
  // Pin only carries the result while its enable is on, so compare there
  capture_feed_a: assert property (capture_route_active_out && result_output_pin_oe_out |->
    capture_ch0_out == result_output_pin_out)
    else $error("capture input differs from result");
  capture_idle_a: assert property (!capture_route_active_out |-> !capture_ch0_out)
    else $error("capture input active without route");
  stop_power_a: assert property (light_stop_mode_in || deepest_stop_mode_in |=> !comparator_power_out)
    else $error("comparator powered in stop");
  stop_irq_a: assert property (light_stop_mode_in |=> !compare_irq_out)
    else $error("interrupt raised in stop");
  light_lowpow_a: assert property (light_stop_mode_in |=> analog_low_power_out)
    else $error("analog not in low power during stop");
  deep_clear_a: assert property (deepest_stop_mode_in |=> !(compare_irq_out || result_output_pin_oe_out
    || capture_route_active_out || reference_source_select_out))
    else $error("control bits survive deepest stop");
  sync_delay_a: assert property ($rose(result_output_pin_out) |-> $past(analog_result_in, 3))
    else $error("result rose before synchroniser delay");
  // Single answer cycle
  answer_one_a: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("waitrequest low longer than one cycle");
  // Main scenarios reached
  cover property ($rose(compare_irq_out));
  cover property (light_stop_mode_in && analog_low_power_out);
  cover property ($fell(avs_waitrequest_out));
endmodule : vcb_comparator_ctrl_chk

bind vcb_comparator_ctrl vcb_comparator_ctrl_chk vcb_comparator_ctrl_chk_inst (.clk_in, .rst_in,
  .light_stop_mode_in, .deepest_stop_mode_in, .analog_result_in, .avs_waitrequest_out, .comparator_power_out,
  .analog_low_power_out, .reference_source_select_out, .result_output_pin_out, .result_output_pin_oe_out,
  .capture_ch0_out, .capture_route_active_out, .timer_channel_zero_pin_disconnect_out, .compare_irq_out);

/* tb/vcb_comparator_ctrl_tb_top.sv */
// Self-checking bench for the comparator control block
`timescale 1ns/10ps
module vcb_comparator_ctrl_tb_top import vcb_pkg::*;
;
  logic clk_in, rst_in, avs_read_in, avs_write_in, wait_mode_in, light_stop_mode_in, deepest_stop_mode_in;
  logic debug_halt_in, analog_result_in, pin_lvl, bg_lvl, avs_waitrequest_out, comparator_power_out;
  logic analog_low_power_out, reference_source_select_out, bandgap_buffer_enable_out, result_output_pin_out;
  logic result_output_pin_oe_out, capture_ch0_out, capture_route_active_out, compare_irq_out;
  logic timer_channel_zero_pin_disconnect_out;
  logic [1:0] e;
  logic [3:0] avs_address_in, avs_byteenable_in;
  logic [31:0] avs_writedata_in, avs_readdata_out, q;
  int error_cnt, compares, cyc, m;
  vcb_comparator_ctrl vcb_comparator_ctrl_inst (.clk_in, .rst_in, .avs_address_in, .avs_read_in, .avs_write_in,
    .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out, .wait_mode_in,
    .light_stop_mode_in, .deepest_stop_mode_in, .debug_halt_in, .analog_result_in, .comparator_power_out,
    .analog_low_power_out, .reference_source_select_out, .bandgap_buffer_enable_out, .result_output_pin_out,
    .result_output_pin_oe_out, .capture_ch0_out, .capture_route_active_out,
    .timer_channel_zero_pin_disconnect_out, .compare_irq_out);
  vcb_analog_model vcb_analog_model_inst (.sel_in(reference_source_select_out), .pin_in(pin_lvl),
    .bandgap_in(bg_lvl), .result_out(analog_result_in));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask : tick
  // One access; leading edge keeps an idle cycle between accesses
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_in);
    avs_address_in <= a;
    avs_writedata_in <= {24'h000000, d};
    avs_write_in <= wr;
    avs_read_in <= !wr;
    // Waitrequest and read data taken at the rising edge, release right after it
    do
    begin
      @(posedge clk_in);
      n++;
    end
    while (avs_waitrequest_out !== 1'b0 && n < 50);
    q = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
    if (n >= 50)
      chk(32'h1, 32'h0);
  endtask : bus
  task automatic conclude();
    if (error_cnt == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  // Clock and hang guard
  initial
  begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  always @(posedge clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      error_cnt++;
      conclude();
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    {rst_in, avs_byteenable_in} = 5'h1f;
    {avs_read_in, avs_write_in, wait_mode_in, light_stop_mode_in, deepest_stop_mode_in} = 5'h00;
    {debug_halt_in, pin_lvl, bg_lvl, avs_address_in, avs_writedata_in} = 39'h0;
    {error_cnt, compares, cyc} = 96'h0;
    tick(2);
    rst_in <= 1'b0;
    bus(1'b0, VCB_ADDR_CTRL, 8'h00);
    chk(q, 32'h0);
    bus(1'b1, 4'hc, 8'hff);
    bus(1'b0, 4'hc, 8'h00);
    chk(q, 32'h0);
    bus(1'b1, VCB_ADDR_SYS, 8'h03);
    @(negedge clk_in);
    chk(bandgap_buffer_enable_out, 1'b1);
    chk(timer_channel_zero_pin_disconnect_out, 1'b1);
    tick(1);
    // Every edge mode, with wait held and debug halt toggled
    wait_mode_in <= 1'b1;
    for (m = 0; m < 4; m++)
    begin
      e = m[1:0];
      debug_halt_in <= e[0];
      bus(1'b1, VCB_ADDR_CTRL, 8'hb4 | {6'h00, e});
      pin_lvl <= 1'b1;
      tick(6);
      bus(1'b0, VCB_ADDR_CTRL, 8'h00);
      chk(q[5], e[0]);
      @(negedge clk_in);
      chk(compare_irq_out, e[0]);
      chk({result_output_pin_oe_out, capture_ch0_out, result_output_pin_out}, 3'h7);
      bus(1'b1, VCB_ADDR_CTRL, 8'hb4 | {6'h00, e});
      bus(1'b0, VCB_ADDR_CTRL, 8'h00);
      chk(q[5], 1'b0);
      pin_lvl <= 1'b0;
      tick(6);
      bus(1'b0, VCB_ADDR_CTRL, 8'h00);
      chk(q[5], e != 2'h1);
    end
    pin_lvl <= 1'b1;
    tick(6);
    bus(1'b0, VCB_ADDR_CTRL, 8'h00);
    chk(q[3], 1'b1);
    // software parks the block during wait
    bus(1'b1, VCB_ADDR_CTRL, 8'h20);
    bus(1'b0, VCB_ADDR_CTRL, 8'h00);
    chk(q, 32'h0);
    chk(comparator_power_out, 1'b0);
    {pin_lvl, bg_lvl} <= 2'h1;
    bus(1'b1, VCB_ADDR_CTRL, 8'hc0);
    tick(6);
    bus(1'b0, VCB_ADDR_CTRL, 8'h00);
    chk(q[3], 1'b1);
    bg_lvl <= 1'b0;
    tick(6);
    bus(1'b1, VCB_ADDR_CTRL, 8'hb3);
    // Pulse while stopped must leave no trace
    light_stop_mode_in <= 1'b1;
    tick(2);
    pin_lvl <= 1'b1;
    tick(6);
    pin_lvl <= 1'b0;
    tick(6);
    bus(1'b1, VCB_ADDR_CTRL, 8'h00);
    bus(1'b0, VCB_ADDR_MODE, 8'h00);
    chk(q, 32'h1);
    @(negedge clk_in);
    chk({analog_low_power_out, comparator_power_out, compare_irq_out}, 3'h4);
    tick(1);
    light_stop_mode_in <= 1'b0;
    bus(1'b0, VCB_ADDR_CTRL, 8'h00);
    chk(q, 32'h93);
    light_stop_mode_in <= 1'b1;
    tick(2);
    // Stop left through reset: reset rises as stop falls
    {rst_in, light_stop_mode_in} <= 2'h2;
    tick(2);
    rst_in <= 1'b0;
    bus(1'b0, VCB_ADDR_CTRL, 8'h00);
    chk(q, 32'h0);
    bus(1'b1, VCB_ADDR_CTRL, 8'h94);
    bus(1'b1, VCB_ADDR_SYS, 8'h03);
    deepest_stop_mode_in <= 1'b1;
    tick(3);
    deepest_stop_mode_in <= 1'b0;
    bus(1'b0, VCB_ADDR_CTRL, 8'h00);
    chk(q, 32'h0);
    bus(1'b0, VCB_ADDR_SYS, 8'h00);
    chk(q, 32'h0);
    conclude();
  end
endmodule : vcb_comparator_ctrl_tb_top
